// File: aad_pkg.sv
// shared constants for the adjust/add instruction decoder
package aad_pkg;
  // opcode bytes
  localparam logic [7:0] OP_ADJ_ADD = 8'h37;
  localparam logic [7:0] OP_ADJ_DIV = 8'hD5;
  localparam logic [7:0] OP_ADJ_MUL = 8'hD4;
  localparam logic [7:0] OP_ADJ_SUB = 8'h3F;
  localparam logic [7:0] OP_ADC_ACC_B = 8'h14;
  localparam logic [7:0] OP_ADC_ACC_W = 8'h15;
  localparam logic [7:0] OP_ADD_ACC_B = 8'h04;
  localparam logic [7:0] OP_ADD_ACC_W = 8'h05;
  localparam logic [7:0] OP_GRP_IB = 8'h80;
  localparam logic [7:0] OP_GRP_IW = 8'h81;
  localparam logic [7:0] OP_GRP_SX = 8'h83;
  localparam logic [5:0] OP_ADC_RM_HI = 6'h04; // 10..13
  localparam logic [5:0] OP_ADD_RM_HI = 6'h00; // 00..03
  localparam logic [7:0] ADJ_BASE = 8'h0A;
  // modrm fields
  localparam int MODRM_REG_LSB = 3;
  localparam int MODRM_MOD_LSB = 6;
  localparam logic [2:0] SUB_ADD = 3'h0;
  localparam logic [2:0] SUB_ADC = 3'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  // clock counts
  localparam logic [4:0] CYC_ADJ_ADD = 5'h08;
  localparam logic [4:0] CYC_ADJ_DIV = 5'h0F;
  localparam logic [4:0] CYC_ADJ_MUL = 5'h13;
  localparam logic [4:0] CYC_ADJ_SUB = 5'h07;
  localparam logic [4:0] CYC_ACC_B = 5'h03;
  localparam logic [4:0] CYC_ACC_W = 5'h04;
  localparam logic [4:0] CYC_IMM_REG = 5'h04;
  localparam logic [4:0] CYC_IMM_MEM = 5'h10;
  localparam logic [4:0] CYC_IMM_MEM_W8 = 5'h14;
  localparam logic [4:0] CYC_RM_REG = 5'h03;
  localparam logic [4:0] CYC_RM_MEM = 5'h0A;
  localparam logic [4:0] CYC_RM_MEM_W8 = 5'h0E;
  // operation classes
  typedef enum logic [3:0] {
    AAD_OP_NONE = 4'h0,
    AAD_OP_ADJ_ADD = 4'h1,
    AAD_OP_ADJ_DIV = 4'h2,
    AAD_OP_ADJ_MUL = 4'h3,
    AAD_OP_ADJ_SUB = 4'h4,
    AAD_OP_ADD = 4'h5,
    AAD_OP_ADC = 4'h6
  } aad_op_t;
  // flag vector bit positions: o s z a p c
  localparam int FL_C = 0;
  localparam int FL_P = 1;
  localparam int FL_A = 2;
  localparam int FL_Z = 3;
  localparam int FL_S = 4;
  localparam int FL_O = 5;
  localparam logic [5:0] UPD_ALL = 6'h3F;
  localparam logic [5:0] UPD_AC = 6'h05;
  localparam logic [5:0] UPD_SZP = 6'h1A;
endpackage

// File: aad_decoder.sv
// decoder and cycle timer for ascii adjust and add instructions
`timescale 1ns/10ps

module aad_decoder #(
  parameter bit NARROW_BUS = 1'b0 // 1 selects the 8-bit bus timing
) (
  input wire logic clk_sys, // 10 MHz core clock
  input wire logic arst_n, // async reset, active low
  input wire logic byte_valid, // instruction byte offered
  input wire logic [7:0] byte_data, // instruction byte
  output logic byte_ready, // decoder takes a byte
  output logic dec_valid, // one-cycle pulse: decode done
  output aad_pkg::aad_op_t dec_op, // operation class
  output logic dec_word, // word operand size
  output logic dec_to_reg, // result goes to the modrm reg operand
  output logic dec_acc, // accumulator form
  output logic dec_mem, // r/m operand is memory
  output logic [2:0] dec_rm, // modrm r/m field
  output logic [2:0] dec_reg, // modrm reg field
  output logic [15:0] dec_imm, // immediate, sign-extended where due
  output logic dec_carry_in, // operation consumes carry
  output logic [5:0] dec_flag_upd, // flags written, osz a p c
  output logic [4:0] dec_cycles, // execution clock count
  output logic dec_illegal, // opcode outside this subset
  output logic busy // execution timer running
);

  typedef enum logic [2:0] {
    AAD_ST_OPC = 3'b000,
    AAD_ST_MODRM = 3'b001,
    AAD_ST_IMM_LO = 3'b011,
    AAD_ST_IMM_HI = 3'b010,
    AAD_ST_BASE = 3'b110,
    AAD_ST_EXEC = 3'b111
  } aad_state_t;

  aad_state_t state, next_state;
  aad_pkg::aad_op_t op, next_op;
  logic word, next_word, to_reg, next_to_reg, acc, next_acc;
  logic mem, next_mem, sx, next_sx;
  logic imm_w, next_imm_w, grp, next_grp, cin, next_cin;
  logic [2:0] rm, next_rm, rg, next_rg;
  logic [15:0] imm, next_imm;
  logic [5:0] upd, next_upd;
  logic [4:0] cyc, next_cyc, cnt, next_cnt;
  logic ill, next_ill, vld, next_vld;

  //////////////////////////////////////////////////////////////////////
  // clock count by form and bus width
  function automatic logic [4:0] rm_cycles(input logic imm_form,
      input logic is_mem, input logic is_word);
    logic [4:0] c;
    c = imm_form ? aad_pkg::CYC_IMM_REG : aad_pkg::CYC_RM_REG;
    if (is_mem) begin
      if (imm_form) begin
        c = (is_word && NARROW_BUS) ? aad_pkg::CYC_IMM_MEM_W8
                                    : aad_pkg::CYC_IMM_MEM;
      end else begin
        c = (is_word && NARROW_BUS) ? aad_pkg::CYC_RM_MEM_W8
                                    : aad_pkg::CYC_RM_MEM;
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // byte-walk decoder and execution timer
  always_comb begin
    next_state = state;
    next_op = op;
    next_word = word;
    next_to_reg = to_reg;
    next_acc = acc;
    next_mem = mem;
    next_sx = sx;
    next_imm_w = imm_w;
    next_grp = grp;
    next_cin = cin;
    next_rm = rm;
    next_rg = rg;
    next_imm = imm;
    next_upd = upd;
    next_cyc = cyc;
    next_cnt = cnt;
    next_ill = 1'b0;
    next_vld = 1'b0;
    case (state)
      AAD_ST_OPC: begin
        // ready is still low on the first clock after reset
        if (byte_valid && byte_ready) begin
          next_op = aad_pkg::AAD_OP_NONE;
          next_word = 1'b0;
          next_to_reg = 1'b0;
          next_acc = 1'b0;
          next_mem = 1'b0;
          next_sx = 1'b0;
          next_imm_w = 1'b0;
          next_grp = 1'b0;
          next_cin = 1'b0;
          next_rm = 3'h0;
          next_rg = 3'h0;
          next_imm = 16'h0000;
          next_upd = aad_pkg::UPD_ALL;
          next_state = AAD_ST_OPC;
          if (byte_data == aad_pkg::OP_ADJ_ADD) begin
            next_op = aad_pkg::AAD_OP_ADJ_ADD;
            next_upd = aad_pkg::UPD_AC;
            next_cyc = aad_pkg::CYC_ADJ_ADD;
            next_state = AAD_ST_EXEC;
          end else if (byte_data == aad_pkg::OP_ADJ_SUB) begin
            next_op = aad_pkg::AAD_OP_ADJ_SUB;
            next_upd = aad_pkg::UPD_AC;
            next_cyc = aad_pkg::CYC_ADJ_SUB;
            next_state = AAD_ST_EXEC;
          end else if (byte_data == aad_pkg::OP_ADJ_DIV) begin
            next_op = aad_pkg::AAD_OP_ADJ_DIV;
            next_word = 1'b1;
            next_upd = aad_pkg::UPD_SZP;
            next_cyc = aad_pkg::CYC_ADJ_DIV;
            next_state = AAD_ST_BASE;
          end else if (byte_data == aad_pkg::OP_ADJ_MUL) begin
            next_op = aad_pkg::AAD_OP_ADJ_MUL;
            next_upd = aad_pkg::UPD_SZP;
            next_cyc = aad_pkg::CYC_ADJ_MUL;
            next_state = AAD_ST_BASE;
          end else if (byte_data == aad_pkg::OP_ADC_ACC_B
              || byte_data == aad_pkg::OP_ADD_ACC_B
              || byte_data == aad_pkg::OP_ADC_ACC_W
              || byte_data == aad_pkg::OP_ADD_ACC_W) begin
            next_cin = byte_data[4];
            next_op = byte_data[4] ? aad_pkg::AAD_OP_ADC
                                   : aad_pkg::AAD_OP_ADD;
            next_word = byte_data[0];
            next_to_reg = 1'b1;
            next_acc = 1'b1;
            next_imm_w = byte_data[0];
            next_cyc = byte_data[0] ? aad_pkg::CYC_ACC_W
                                    : aad_pkg::CYC_ACC_B;
            next_state = AAD_ST_IMM_LO;
          end else if (byte_data == aad_pkg::OP_GRP_IB
              || byte_data == aad_pkg::OP_GRP_IW
              || byte_data == aad_pkg::OP_GRP_SX) begin
            next_grp = 1'b1;
            next_word = byte_data[0];
            next_imm_w = (byte_data == aad_pkg::OP_GRP_IW);
            next_sx = (byte_data == aad_pkg::OP_GRP_SX);
            next_state = AAD_ST_MODRM;
          end else if (byte_data[7:2] == aad_pkg::OP_ADC_RM_HI
              || byte_data[7:2] == aad_pkg::OP_ADD_RM_HI) begin
            next_cin = byte_data[4];
            next_op = byte_data[4] ? aad_pkg::AAD_OP_ADC
                                   : aad_pkg::AAD_OP_ADD;
            next_word = byte_data[0];
            next_to_reg = byte_data[1];
            next_state = AAD_ST_MODRM;
          end else begin
            next_ill = 1'b1;
            next_vld = 1'b1;
          end
        end
      end
      AAD_ST_MODRM: begin
        if (byte_valid) begin
          next_rm = byte_data[2:0];
          next_rg = byte_data[aad_pkg::MODRM_REG_LSB +: 3];
          next_mem = byte_data[aad_pkg::MODRM_MOD_LSB +: 2]
                     != aad_pkg::MOD_REG;
          next_cyc = rm_cycles(grp, next_mem, word);
          if (grp) begin
            next_state = AAD_ST_IMM_LO;
            if (next_rg == aad_pkg::SUB_ADC) begin
              next_op = aad_pkg::AAD_OP_ADC;
              next_cin = 1'b1;
            end else if (next_rg == aad_pkg::SUB_ADD) begin
              next_op = aad_pkg::AAD_OP_ADD;
            end else begin
              // other group members belong to other blocks
              next_ill = 1'b1;
              next_vld = 1'b1;
              next_state = AAD_ST_OPC;
            end
          end else begin
            next_state = AAD_ST_EXEC;
          end
        end
      end
      AAD_ST_IMM_LO: begin
        if (byte_valid) begin
          next_imm = {{8{sx & byte_data[7]}}, byte_data};
          next_state = imm_w ? AAD_ST_IMM_HI : AAD_ST_EXEC;
        end
      end
      AAD_ST_IMM_HI: begin
        if (byte_valid) begin
          next_imm = {byte_data, imm[7:0]};
          next_state = AAD_ST_EXEC;
        end
      end
      AAD_ST_BASE: begin
        if (byte_valid) begin
          // only the decimal base is in this subset
          if (byte_data == aad_pkg::ADJ_BASE) begin
            next_imm = {8'h00, byte_data};
            next_state = AAD_ST_EXEC;
          end else begin
            next_ill = 1'b1;
            next_vld = 1'b1;
            next_state = AAD_ST_OPC;
          end
        end
      end
      AAD_ST_EXEC: begin
        // decode is announced, then the timer runs its full count
        if (cnt == 5'h00) begin
          next_vld = 1'b1;
          next_cnt = cyc - 5'h01;
          if (cyc == 5'h01) begin
            next_state = AAD_ST_OPC;
          end
        end else if (cnt == 5'h01) begin
          next_cnt = 5'h00;
          next_state = AAD_ST_OPC;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      default: begin
        next_state = AAD_ST_OPC;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= AAD_ST_OPC;
      op <= aad_pkg::AAD_OP_NONE;
      word <= 1'b0;
      to_reg <= 1'b0;
      acc <= 1'b0;
      mem <= 1'b0;
      sx <= 1'b0;
      imm_w <= 1'b0;
      grp <= 1'b0;
      cin <= 1'b0;
      rm <= 3'h0;
      rg <= 3'h0;
      imm <= 16'h0000;
      upd <= 6'h00;
      cyc <= 5'h00;
      cnt <= 5'h00;
      ill <= 1'b0;
      vld <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      word <= next_word;
      to_reg <= next_to_reg;
      acc <= next_acc;
      mem <= next_mem;
      sx <= next_sx;
      imm_w <= next_imm_w;
      grp <= next_grp;
      cin <= next_cin;
      rm <= next_rm;
      rg <= next_rg;
      imm <= next_imm;
      upd <= next_upd;
      cyc <= next_cyc;
      cnt <= next_cnt;
      ill <= next_ill;
      vld <= next_vld;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs; byte_ready low while executing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byte_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      byte_ready <= (next_state != AAD_ST_EXEC);
      busy <= (next_state == AAD_ST_EXEC);
    end
  end

  assign dec_valid = vld;
  assign dec_op = op;
  assign dec_word = word;
  assign dec_to_reg = to_reg;
  assign dec_acc = acc;
  assign dec_mem = mem;
  assign dec_rm = rm;
  assign dec_reg = rg;
  assign dec_imm = imm;
  assign dec_carry_in = cin;
  assign dec_flag_upd = upd;
  assign dec_cycles = cyc;
  assign dec_illegal = ill;

endmodule // aad_decoder

// File: aad_decoder_monitor.sv
// concurrent checks on the adjust/add decoder ports
`timescale 1ns/10ps
module aad_decoder_monitor (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic byte_ready, // decoder takes a byte
  input wire logic busy, // timer running
  input wire logic dec_valid, // decode done pulse
  input wire logic dec_illegal, // opcode outside subset
  input wire aad_pkg::aad_op_t dec_op, // operation class
  input wire logic [4:0] dec_cycles, // clock count
  input wire logic [5:0] dec_flag_upd, // flags written
  input wire logic dec_carry_in, // carry consumed
  input wire logic dec_mem, // memory operand
  input wire logic dec_acc, // accumulator form
  input wire logic [15:0] dec_imm // immediate
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////
  // execution starts when ready drops after the last byte
  sequence s_launch;
    $fell(byte_ready);
  endsequence
  // a finished decode of one class
  sequence s_done(aad_pkg::aad_op_t o);
    dec_valid && !dec_illegal && dec_op == o;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  // handshake shape; no opcode runs shorter than three clocks
  a_answer_after_launch: assert property (s_launch |=>
    dec_valid && !dec_illegal)
    else $error("no decode one clock after launch");
  a_exec_min_len: assert property (s_launch |-> !byte_ready [*3])
    else $error("execution shorter than three clocks");
  a_busy_blocks_ready: assert property (busy |-> !byte_ready)
    else $error("ready while busy");
  // clocks spent busy in the current execution
  logic [4:0] busy_len;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_len <= 5'h00;
    end else begin
      busy_len <= busy ? busy_len + 5'h01 : 5'h00;
    end
  end
  a_busy_len_match: assert property (
    $fell(busy) |-> busy_len == dec_cycles)
    else $error("busy length differs from clock count");
  a_valid_one_pulse: assert property (dec_valid |=> !dec_valid)
    else $error("decode pulse longer than a clock");
  a_illegal_with_valid: assert property (dec_illegal |-> dec_valid)
    else $error("illegal flag without decode pulse");
  // adjust instructions: fixed counts and flag sets
  a_adj_add_timing: assert property (s_done(aad_pkg::AAD_OP_ADJ_ADD) |->
    dec_cycles == 5'h08 && dec_flag_upd == 6'h05) else $error("adjust add");
  a_adj_div_timing: assert property (s_done(aad_pkg::AAD_OP_ADJ_DIV) |->
    dec_cycles == 5'h0F && dec_flag_upd == 6'h1A && dec_imm == 16'h000A)
    else $error("adjust divide");
  a_adj_mul_timing: assert property (s_done(aad_pkg::AAD_OP_ADJ_MUL) |->
    dec_cycles == 5'h13 && dec_flag_upd == 6'h1A && dec_imm == 16'h000A)
    else $error("adjust multiply");
  a_adj_sub_timing: assert property (s_done(aad_pkg::AAD_OP_ADJ_SUB) |->
    dec_cycles == 5'h07 && dec_flag_upd == 6'h05) else $error("adjust sub");
  // arithmetic: carry use, all flags, memory operand counts
  a_carry_use_match: assert property (dec_valid && !dec_illegal |->
    dec_carry_in == (dec_op == aad_pkg::AAD_OP_ADC)) else $error("carry use");
  a_arith_all_flags: assert property (s_done(aad_pkg::AAD_OP_ADD) or
    s_done(aad_pkg::AAD_OP_ADC) |-> dec_flag_upd == 6'h3F) else $error("flags");
  a_mem_slow_count: assert property ((s_done(aad_pkg::AAD_OP_ADD) or
    s_done(aad_pkg::AAD_OP_ADC)) and (dec_mem && !dec_acc) |->
    dec_cycles inside {5'h0A, 5'h0E, 5'h10, 5'h14}) else $error("mem count");
endmodule // aad_decoder_monitor

bind aad_decoder aad_decoder_monitor u_mon (.clk_sys(clk_sys),
  .arst_n(arst_n), .byte_ready(byte_ready), .busy(busy),
  .dec_valid(dec_valid), .dec_illegal(dec_illegal), .dec_op(dec_op),
  .dec_cycles(dec_cycles), .dec_flag_upd(dec_flag_upd),
  .dec_carry_in(dec_carry_in), .dec_mem(dec_mem), .dec_acc(dec_acc),
  .dec_imm(dec_imm));

// File: ascii_adjust_add_decoder_bench.sv
// self-checking bench for the adjust/add decoder
`timescale 1ns/10ps
module ascii_adjust_add_decoder_bench;
  logic clk_sys, arst_n, byte_valid, byte_ready, dec_valid, dec_word;
  logic dec_to_reg, dec_acc, dec_mem, dec_carry_in, dec_illegal, busy;
  logic [7:0] byte_data;
  logic [2:0] dec_rm, dec_reg;
  logic [15:0] dec_imm;
  logic [5:0] dec_flag_upd;
  logic [4:0] dec_cycles;
  logic nb_ready, nb_valid;
  logic [4:0] nb_cycles;
  aad_pkg::aad_op_t dec_op;
  int fails, checks, cyc, i;
  logic [7:0] ops [16] = '{8'h37, 8'h3F, 8'hD5, 8'hD4, 8'h14, 8'h15, 8'h04,
    8'h05, 8'h80, 8'h81, 8'h83, 8'h00, 8'h01, 8'h12, 8'h13, 8'h10};
  aad_decoder #(.NARROW_BUS(1'b0)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_word(dec_word),
    .dec_to_reg(dec_to_reg), .dec_acc(dec_acc), .dec_mem(dec_mem),
    .dec_rm(dec_rm), .dec_reg(dec_reg), .dec_imm(dec_imm),
    .dec_carry_in(dec_carry_in), .dec_flag_upd(dec_flag_upd),
    .dec_cycles(dec_cycles), .dec_illegal(dec_illegal), .busy(busy));
  // same byte stream into the 8-bit bus build for its slower counts
  aad_decoder #(.NARROW_BUS(1'b1)) DUT_NARROW (.clk_sys(clk_sys),
    .arst_n(arst_n), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(nb_ready), .dec_valid(nb_valid), .dec_op(), .dec_word(),
    .dec_to_reg(), .dec_acc(), .dec_mem(), .dec_rm(), .dec_reg(),
    .dec_imm(), .dec_carry_in(), .dec_flag_upd(), .dec_cycles(nb_cycles),
    .dec_illegal(), .busy());
  //////////////////////////////////////////////////////////////////////////
  // 10 MHz clock and a cycle ceiling well above the expected run
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // offer a byte at a falling edge once ready; held until taken
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_sys);
    while ((byte_ready & nb_ready) !== 1'b1 && n < 60) begin
      byte_valid = 1'b0;
      n++;
      @(negedge clk_sys);
    end
    chk(n < 60, "ready never returned");
    byte_valid = 1'b1;
    byte_data = b;
  endtask
  // send one instruction and compare the decode with the expectation
  task automatic run(input logic [7:0] o, m, input logic [15:0] im);
    logic grp, rmf, acc, adj, w, mem, ill;
    logic [4:0] cy, cn;
    logic [5:0] up;
    aad_pkg::aad_op_t op;
    int n, k;
    grp = o inside {8'h80, 8'h81, 8'h83};
    rmf = o[7:2] == 6'h00 || o[7:2] == 6'h04;
    acc = o inside {8'h04, 8'h05, 8'h14, 8'h15};
    adj = o inside {8'hD4, 8'hD5};
    w = grp ? o != 8'h80 : o[0];
    mem = m[7:6] != 2'h3;
    ill = (grp && !(m[5:3] inside {3'h0, 3'h2})) || (adj && m != 8'h0A);
    op = (o[7:3] == 5'h02 || (grp && m[5:3] == 3'h2)) ? aad_pkg::AAD_OP_ADC :
      aad_pkg::AAD_OP_ADD;
    cy = acc ? (w ? 5'h04 : 5'h03) : grp ? (mem ? 5'h10 : 5'h04) :
      mem ? 5'h0A : 5'h03;
    up = 6'h3F;
    case (o)
      8'h37: begin op = aad_pkg::AAD_OP_ADJ_ADD; cy = 5'h08; up = 6'h05; end
      8'h3F: begin op = aad_pkg::AAD_OP_ADJ_SUB; cy = 5'h07; up = 6'h05; end
      8'hD5: begin op = aad_pkg::AAD_OP_ADJ_DIV; cy = 5'h0F; up = 6'h1A; end
      8'hD4: begin op = aad_pkg::AAD_OP_ADJ_MUL; cy = 5'h13; up = 6'h1A; end
      default: ;
    endcase
    // word memory forms are slower on the 8-bit bus
    cn = (mem && w && (grp || rmf)) ? (grp ? 5'h14 : 5'h0E) : cy;
    put(o);
    if (adj || grp || rmf) put(m);
    if (!ill && (acc || grp)) put(im[7:0]);
    if (!ill && o inside {8'h05, 8'h15, 8'h81}) put(im[15:8]);
    if (o == 8'h83) im = {{8{im[7]}}, im[7:0]};
    n = 0;
    @(negedge clk_sys);
    byte_valid = 1'b0;
    while (dec_valid !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk_sys);
    end
    chk(dec_valid === 1'b1, "no decode pulse");
    chk(nb_valid === 1'b1, "no decode pulse, 8-bit build");
    chk(dec_illegal === ill, "illegal flag");
    if (ill) return;
    chk(busy === 1'b1, "not busy during execution");
    chk(dec_op === op, "operation class");
    chk(dec_cycles === cy, "clock count");
    chk(dec_flag_upd === up, "flag set");
    chk(dec_carry_in === (op == aad_pkg::AAD_OP_ADC), "carry");
    if (adj) chk(dec_imm === 16'h000A, "adjust base");
    if (acc || grp) chk(dec_imm[7:0] === im[7:0] && (!w || dec_imm === im),
      "immediate");
    if (grp || rmf) chk(dec_mem === mem && dec_reg === m[5:3] &&
      dec_rm === m[2:0] && dec_word === w, "modrm fields");
    chk(dec_to_reg === (acc || (rmf && o[1])), "destination");
    chk(dec_acc === acc, "accumulator form");
    chk(nb_cycles === cn, "clock count, 8-bit build");
    // ready must stay low for exactly the stated count of clocks
    n = 1;
    k = 0;
    while ((byte_ready & nb_ready) !== 1'b1 && n < 40) begin
      if (byte_ready === 1'b1 && k == 0) k = n;
      n++;
      @(negedge clk_sys);
    end
    if (k == 0) k = n;
    chk(k == int'(cy), "execution length");
    chk(n == int'(cn), "execution length, 8-bit build");
  endtask
  //////////////////////////////////////////////////////////////////////////
  // reset, corner cases, then random traffic
  initial begin
    fails = 0;
    checks = 0;
    cyc = 0;
    arst_n = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    void'($urandom(8));
    repeat (20) @(negedge clk_sys);
    chk(byte_ready === 1'b0 && busy === 1'b0 && dec_valid === 1'b0,
      "reset values");
    arst_n = 1'b1;
    @(negedge clk_sys);
    chk(byte_ready === 1'b1 && nb_ready === 1'b1, "ready after reset");
    @(negedge clk_sys);
    run(8'hD4, 8'h0B, 16'h0000);
    run(8'h80, 8'hE8, 16'h0000);
    run(8'h83, 8'h10, 16'h0080);
    run(8'h83, 8'hC2, 16'h007F);
    run(8'h81, 8'h16, 16'hBEEF);
    run(8'h04, 8'h00, 16'h00FF);
    // reset in the middle of an execution drops back to the opcode state
    put(8'hD4);
    put(8'h0A);
    @(negedge clk_sys);
    byte_valid = 1'b0;
    arst_n = 1'b0;
    @(negedge clk_sys);
    chk(byte_ready === 1'b0 && busy === 1'b0 && dec_valid === 1'b0,
      "values in mid-run reset");
    arst_n = 1'b1;
    @(negedge clk_sys);
    chk(byte_ready === 1'b1 && busy === 1'b0, "ready after mid-run reset");
    for (i = 0; i < 16; i++) run(ops[i], 8'h0A, 16'h1234);
    for (i = 0; i < 120; i++) begin
      logic [7:0] o, m;
      o = ops[$urandom % 16];
      m = 8'($urandom);
      if (o inside {8'h80, 8'h81, 8'h83}) m[5:3] = {1'b0, 1'($urandom), 1'b0};
      if (o inside {8'hD4, 8'hD5}) m = 8'h0A;
      run(o, m, 16'($urandom));
    end
    summarize();
  end
endmodule // ascii_adjust_add_decoder_bench
